// ==== rtl/rlps_pkg.sv ====
package rlps_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_PS  = 8000;
   localparam int T_CO_MIN_PS    = 25000;
   localparam int HALF_CYC       = (T_CO_MIN_PS / 2 + CLK_PERIOD_PS - 1)
                                   / CLK_PERIOD_PS;
   localparam int LOCK_TICKS     = 4096;
   localparam int VEC_HALVES     = 36;
   localparam int POR_TICKS      = 128;
   localparam int WD_TICKS       = 128;
   localparam int RST_MIN_TICKS  = 8;
   localparam int WAKE_CPU_CYC   = 12;
   localparam int WAKE_PER_CYC   = 15;
   localparam int IDLE_STOP_CYC  = 4;
   localparam int CNT_W          = 24;
   localparam int LOW_W          = 4;
   localparam int DIV_W          = 4;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      RLPS_MODE_RUN,
      RLPS_MODE_CPU_IDLE,
      RLPS_MODE_PER_IDLE,
      RLPS_MODE_HALT
   } rlps_mode_type;

   typedef enum logic [3:0] {
      ST_POR, ST_PINWAIT, ST_LOCK, ST_VEC, ST_RUN, ST_STOP,
      ST_IDLE, ST_OSC, ST_RELOCK, ST_WAKE, ST_WD
   } rlps_state_type;

   typedef struct packed {
      logic          idle_req;
      rlps_mode_type idle_mode;
      logic          wake_irq;
      logic          watchdog;
   } rlps_ctrl_type;

   typedef struct packed {
      rlps_state_type st;
      rlps_mode_type  mode;
      logic [CNT_W-1:0] cnt;
      logic [LOW_W-1:0] lowcnt;
      logic [DIV_W-1:0] div;
      logic           ref_prev;
      logic           clk_out;
      logic           clk_run;
      logic           pin_out;
      logic           pin_oe;
      logic           core_reset;
      logic           core_run;
      logic           pll_en;
      logic           osc_en;
   } rlps_regs_type;

endpackage

// ==== rtl/rlps_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module rlps_sequencer #(
   parameter int OSC_START_CYC = 125000
) (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   ref_clock_input,
   input  wire logic                   reset_pin_in,
   output var  logic                   reset_pin_out,
   output var  logic                   reset_pin_oe,
   input  wire rlps_pkg::rlps_ctrl_type ctrl,
   output var  logic                   system_clock_output,
   output var  logic                   core_reset,
   output var  logic                   core_run,
   output var  logic                   pll_enable,
   output var  logic                   osc_enable,
   output var  rlps_pkg::rlps_mode_type low_power_mode
);
   import rlps_pkg::*;

   if (OSC_START_CYC < 1 || OSC_START_CYC >= (1 << CNT_W)) begin : g_bad
      $error("OSC_START_CYC out of range");
   end

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [1:0] pins_s;

   rlps_sync #(.W(2)) u_sync (
      .clk   (clk),
      .reset (reset),
      .d     ({ref_clock_input, reset_pin_in}),
      .q     (pins_s)
   );

   rlps_regs_type s_q;
   rlps_regs_type s_d;

   function automatic logic hit(input logic [CNT_W-1:0] c, input int n);
      hit = (c == CNT_W'(n - 1));
   endfunction

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   logic tick;
   logic hp;
   logic rise;
   logic ext_rst;

   always_comb begin
      s_d         = s_q;
      s_d.ref_prev = pins_s[1];
      tick        = pins_s[1] & ~s_q.ref_prev;
      hp          = (s_q.div == DIV_W'(HALF_CYC - 1));
      s_d.div     = hp ? '0 : s_q.div + DIV_W'(1);
      rise        = hp & s_q.clk_run & ~s_q.clk_out;
      // A stop lets a low phase finish, so the clock parks high
      if (hp && (s_q.clk_run || !s_q.clk_out))
         s_d.clk_out = ~s_q.clk_out;

      // Pin low must last the minimum width to count
      if (!pins_s[0] && !s_q.pin_oe) begin
         if (tick && s_q.lowcnt != LOW_W'(RST_MIN_TICKS))
            s_d.lowcnt = s_q.lowcnt + LOW_W'(1);
      end else begin
         s_d.lowcnt = '0;
      end
      ext_rst = (s_q.lowcnt == LOW_W'(RST_MIN_TICKS));

      if (ext_rst && s_q.st != ST_PINWAIT && s_q.st != ST_POR
          && s_q.st != ST_WD) begin
         s_d.st         = ST_PINWAIT;
         s_d.core_reset = 1'b1;
         s_d.core_run   = 1'b0;
         s_d.pll_en     = 1'b0;
         s_d.osc_en     = 1'b1;
         s_d.clk_run    = 1'b0;
         s_d.mode       = RLPS_MODE_RUN;
      end else begin
         unique case (s_q.st)
            ST_POR: begin
               if (tick)
                  s_d.cnt = s_q.cnt + CNT_W'(1);
               if (tick && hit(s_q.cnt, POR_TICKS)) begin
                  s_d.pin_oe = 1'b0;
                  s_d.st     = ST_PINWAIT;
                  s_d.cnt    = '0;
               end
            end
            ST_PINWAIT: begin
               if (pins_s[0] && !s_q.pin_oe) begin
                  s_d.st     = ST_LOCK;
                  s_d.pll_en = 1'b1;
                  s_d.cnt    = '0;
               end
            end
            ST_LOCK, ST_RELOCK: begin
               if (tick)
                  s_d.cnt = s_q.cnt + CNT_W'(1);
               if (tick && hit(s_q.cnt, LOCK_TICKS)) begin
                  s_d.clk_run = 1'b1;
                  s_d.cnt     = '0;
                  s_d.st      = (s_q.st == ST_LOCK) ? ST_VEC : ST_WAKE;
               end
            end
            ST_VEC: begin
               if (hp) begin
                  s_d.cnt = s_q.cnt + CNT_W'(1);
                  if (hit(s_q.cnt, VEC_HALVES)) begin
                     s_d.core_reset = 1'b0;
                     s_d.core_run   = 1'b1;
                     s_d.st         = ST_RUN;
                     s_d.cnt        = '0;
                  end
               end
            end
            ST_RUN: begin
               if (ctrl.watchdog) begin
                  s_d.st         = ST_WD;
                  s_d.pin_oe     = 1'b1;
                  s_d.core_reset = 1'b1;
                  s_d.core_run   = 1'b0;
                  s_d.pll_en     = 1'b0;
                  s_d.clk_run    = 1'b0;
                  s_d.cnt        = '0;
               end else if (ctrl.idle_req
                            && ctrl.idle_mode != RLPS_MODE_RUN) begin
                  s_d.mode     = ctrl.idle_mode;
                  s_d.core_run = 1'b0;
                  s_d.cnt      = '0;
                  s_d.st       = (ctrl.idle_mode == RLPS_MODE_CPU_IDLE)
                                 ? ST_IDLE : ST_STOP;
               end
            end
            ST_STOP: begin
               if (rise) begin
                  s_d.cnt = s_q.cnt + CNT_W'(1);
                  if (hit(s_q.cnt, IDLE_STOP_CYC)) begin
                     // Edge in flight leaves the clock parked high
                     s_d.clk_run = 1'b0;
                     s_d.st      = ST_IDLE;
                     s_d.cnt     = '0;
                     if (s_q.mode == RLPS_MODE_HALT) begin
                        s_d.pll_en = 1'b0;
                        s_d.osc_en = 1'b0;
                     end
                  end
               end
            end
            ST_IDLE: begin
               if (ctrl.wake_irq) begin
                  s_d.cnt = '0;
                  if (s_q.mode == RLPS_MODE_HALT) begin
                     s_d.osc_en = 1'b1;
                     s_d.st     = ST_OSC;
                  end else begin
                     s_d.clk_run = 1'b1;
                     s_d.st      = ST_WAKE;
                  end
               end
            end
            ST_OSC: begin
               s_d.cnt = s_q.cnt + CNT_W'(1);
               if (hit(s_q.cnt, OSC_START_CYC)) begin
                  // Divider untouched, so same frequency as before
                  s_d.pll_en = 1'b1;
                  s_d.st     = ST_RELOCK;
                  s_d.cnt    = '0;
               end
            end
            ST_WAKE: begin
               if (rise || (s_q.mode == RLPS_MODE_CPU_IDLE && hp
                            && !s_q.clk_out)) begin
                  s_d.cnt = s_q.cnt + CNT_W'(1);
                  if (hit(s_q.cnt, (s_q.mode == RLPS_MODE_CPU_IDLE)
                                   ? WAKE_CPU_CYC : WAKE_PER_CYC)) begin
                     s_d.core_run = 1'b1;
                     s_d.mode     = RLPS_MODE_RUN;
                     s_d.st       = ST_RUN;
                     s_d.cnt      = '0;
                  end
               end
            end
            ST_WD: begin
               if (tick)
                  s_d.cnt = s_q.cnt + CNT_W'(1);
               // First tick may predate the drive, so count one more
               if (tick && hit(s_q.cnt, WD_TICKS + 1)) begin
                  s_d.pin_oe = 1'b0;
                  s_d.st     = ST_PINWAIT;
                  s_d.cnt    = '0;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q            <= '0;
         s_q.st         <= ST_POR;
         s_q.mode       <= RLPS_MODE_RUN;
         s_q.clk_out    <= 1'b1;
         s_q.ref_prev   <= 1'b1;
         s_q.pin_oe     <= 1'b1;
         s_q.core_reset <= 1'b1;
         s_q.osc_en     <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign reset_pin_out       = s_q.pin_out;
   assign reset_pin_oe        = s_q.pin_oe;
   assign system_clock_output = s_q.clk_out;
   assign core_reset          = s_q.core_reset;
   assign core_run            = s_q.core_run;
   assign pll_enable          = s_q.pll_en;
   assign osc_enable          = s_q.osc_en;
   assign low_power_mode      = s_q.mode;
endmodule
`default_nettype wire

// ==== rtl/rlps_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module rlps_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= '1;
         q      <= '1;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ==== tb/rlps_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module rlps_asserts (
   input wire logic                   clk,
   input wire logic                   reset,
   input wire logic                   ref_clock_input,
   input wire logic                   reset_pin_out,
   input wire logic                   reset_pin_oe,
   input wire rlps_pkg::rlps_ctrl_type ctrl,
   input wire logic                   system_clock_output,
   input wire logic                   core_reset,
   input wire logic                   core_run,
   input wire logic                   pll_enable,
   input wire logic                   osc_enable,
   input wire rlps_pkg::rlps_mode_type low_power_mode
);
   import rlps_pkg::*;
   logic        ref_q;
   logic [12:0] oe_n;
   logic [12:0] lk_n;
   wire         tk = ref_clock_input & ~ref_q;
   // ----
   // Reference ticks while driving and locking
   // ----
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ref_q <= 1'b0;
         oe_n  <= '0;
         lk_n  <= '0;
      end else begin
         ref_q <= ref_clock_input;
         oe_n  <= reset_pin_oe ? oe_n + 13'(tk) : '0;
         lk_n  <= (pll_enable & core_reset) ? lk_n + 13'(tk) : '0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_low_two;
      !system_clock_output ##1 !system_clock_output ##1 system_clock_output;
   endsequence
   a_wd_take: assert property (
      ctrl.watchdog && core_run |=> reset_pin_oe
      && core_reset && !core_run && !pll_enable)
      else $error("watchdog not taken");
   a_idle_take: assert property (
      ctrl.idle_req && core_run && !ctrl.watchdog
      && ctrl.idle_mode != RLPS_MODE_RUN |=> !core_run
      && low_power_mode == $past(ctrl.idle_mode))
      else $error("idle not taken");
   a_pin_drive: assert property (reset_pin_oe |-> !reset_pin_out)
      else $error("pin driven high");
   a_oe_width: assert property (
      $fell(reset_pin_oe) |-> oe_n >= 13'd128)
      else $error("pin drive too short");
   a_lock_span: assert property (
      $fell(core_reset) |-> lk_n >= 13'd4095 && core_run)
      else $error("released before lock");
   a_clk_duty: assert property (
      $fell(system_clock_output) |-> s_low_two)
      else $error("output low phase wrong");
   a_halt_off: assert property (
      $fell(pll_enable) && low_power_mode == RLPS_MODE_HALT
      |-> $fell(osc_enable))
      else $error("oscillator left on");
   a_cpu_clock: assert property (
      low_power_mode == RLPS_MODE_CPU_IDLE |-> ##[0:3] !system_clock_output)
      else $error("clock stopped in cpu idle");
   a_run_mode: assert property (
      core_run |-> !core_reset && low_power_mode == RLPS_MODE_RUN)
      else $error("running in low power");
endmodule
`default_nettype wire

// ==== tb/rlps_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module rlps_partner (
   input  wire logic ext_low,
   input  wire logic reset_pin_out,
   input  wire logic reset_pin_oe,
   input  wire logic core_reset,
   output var  logic ref_clock_input,
   output var  logic test_reset_n,
   output wire logic reset_pin_in
);
   // Emulator keeps its test reset low until the core leaves reset
   initial begin
      test_reset_n = 1'b0;
      @(negedge core_reset);
      test_reset_n = 1'b1;
   end
   // Free-running reference, stable from time zero
   initial begin
      ref_clock_input = 1'b0;
      #1;
      forever #16 ref_clock_input = ~ref_clock_input;
   end
   // Pulled-up pin, low while either side pulls
   assign reset_pin_in = ~(ext_low | (reset_pin_oe & ~reset_pin_out));
endmodule
`default_nettype wire

// ==== tb/test_reset_lowpower_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_reset_lowpower_sequencer;
   import rlps_pkg::*;
   logic          clk;
   logic          reset;
   logic          ext_low;
   wire logic     ref_clock_input;
   wire logic     reset_pin_in;
   logic          reset_pin_out;
   logic          reset_pin_oe;
   rlps_ctrl_type ctrl;
   logic          system_clock_output;
   logic          core_reset;
   logic          core_run;
   logic          pll_enable;
   logic          osc_enable;
   rlps_mode_type low_power_mode;
   logic          test_reset_n;
   int            fails;
   int            total_checks;
   rlps_sequencer #(.OSC_START_CYC(20)) dut_u (.clk, .reset,
      .ref_clock_input, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
      .ctrl, .system_clock_output, .core_reset, .core_run, .pll_enable,
      .osc_enable, .low_power_mode);
   rlps_partner far_u (.ext_low, .reset_pin_out, .reset_pin_oe,
      .core_reset, .ref_clock_input, .test_reset_n, .reset_pin_in);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic check(input string nm, input logic [15:0] seen,
                        input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ----
   // Tick and edge counters
   // ----
   task automatic cnt_oe(output int tk);
      logic p;
      tk = 0;
      p = ref_clock_input;
      for (int i = 0; i < 2000 && reset_pin_oe === 1'b1; i++) begin
         @(negedge clk);
         if (ref_clock_input && !p) tk++;
         p = ref_clock_input;
      end
   endtask
   task automatic relock(output int tk, output int vc, output int ed);
      logic p;
      logic s;
      tk = 0;
      vc = 0;
      ed = 0;
      p = ref_clock_input;
      s = system_clock_output;
      for (int i = 0; i < 20000 && core_run !== 1'b1; i++) begin
         @(negedge clk);
         if (pll_enable === 1'b1 && ref_clock_input && !p) tk++;
         if (system_clock_output && !s) ed++;
         if (vc > 0 || !system_clock_output) vc++;
         p = ref_clock_input;
         s = system_clock_output;
      end
      check("run", core_run, 1'b1);
   endtask
   task automatic t_por();
      int tk, vc, ed;
      cnt_oe(tk);
      check("por_hold", tk >= 128 && tk <= 131, 1'b1);
      check("trst_low", test_reset_n, 1'b0);
      relock(tk, vc, ed);
      check("trst_up", test_reset_n, 1'b1);
      check("por_lock", tk >= 4096 && tk <= 4120, 1'b1);
      check("vector", vc >= 70 && vc <= 74, 1'b1);
   endtask
   task automatic t_clk();
      int   e;
      int   n;
      int   hi;
      int   p;
      logic s;
      e = 0;
      n = 0;
      hi = 0;
      s = system_clock_output;
      for (int i = 0; i < 64; i++) begin
         @(negedge clk);
         if (system_clock_output && !s) e++;
         if (e == 1) n++;
         if (e == 1 && system_clock_output) hi++;
         s = system_clock_output;
      end
      p = n * CLK_PERIOD_PS;
      check("clk_period", p >= T_CO_MIN_PS && p <= 250000, 1'b1);
      check("clk_duty", hi * 2, n);
   endtask
   task automatic t_pin(input int n, input logic hit);
      int tk, vc, ed;
      @(negedge clk);
      ext_low = 1'b1;
      repeat (n * 4) @(negedge clk);
      check("pin_req", core_reset, hit);
      ext_low = 1'b0;
      if (hit) relock(tk, vc, ed);
      else repeat (40) @(negedge clk);
      check("pin_run", core_run, 1'b1);
   endtask
   task automatic t_wd();
      int tk, vc, ed;
      @(negedge clk);
      ctrl.watchdog = 1'b1;
      @(negedge clk);
      ctrl.watchdog = 1'b0;
      check("wd_oe", reset_pin_oe, 1'b1);
      check("wd_drive", reset_pin_out, 1'b0);
      cnt_oe(tk);
      check("wd_hold", tk >= 128 && tk <= 131, 1'b1);
      relock(tk, vc, ed);
      check("wd_lock", tk >= 4096 && tk <= 4120, 1'b1);
   endtask
   task automatic t_idle(input rlps_mode_type m, input int res);
      int tk, vc, ed;
      @(negedge clk);
      ctrl.idle_req = 1'b1;
      ctrl.idle_mode = m;
      @(negedge clk);
      ctrl.idle_req = 1'b0;
      ctrl.watchdog = 1'b1;
      check("idle_run", core_run, 1'b0);
      check("idle_mode", low_power_mode, m);
      @(negedge clk);
      ctrl.watchdog = 1'b0;
      repeat (40) @(negedge clk);
      check("wd_ignored", reset_pin_oe, 1'b0);
      if (m != RLPS_MODE_CPU_IDLE) check("parked", system_clock_output, 1);
      check("pll", pll_enable, m != RLPS_MODE_HALT);
      check("osc", osc_enable, m != RLPS_MODE_HALT);
      ctrl.wake_irq = 1'b1;
      @(negedge clk);
      ctrl.wake_irq = 1'b0;
      relock(tk, vc, ed);
      check("resume", ed + 1 >= res && ed <= res + 1, 1'b1);
      if (m == RLPS_MODE_HALT) check("halt_lock", tk >= 4096, 1'b1);
   endtask
   initial begin
      #750000;
      fails++;
      summarize();
   end
   initial begin
      fails = 0;
      total_checks = 0;
      reset = 1'b1;
      ext_low = 1'b0;
      ctrl = '0;
      repeat (20) @(negedge clk);
      reset = 1'b0;
      t_por();
      t_clk();
      t_pin(3, 1'b0);
      t_pin(12, 1'b1);
      t_wd();
      t_idle(RLPS_MODE_CPU_IDLE, 12);
      t_idle(RLPS_MODE_PER_IDLE, 15);
      t_idle(RLPS_MODE_HALT, 15);
      summarize();
   end
endmodule
bind rlps_sequencer rlps_asserts chk_u (.clk, .reset, .ref_clock_input,
   .reset_pin_out, .reset_pin_oe, .ctrl, .system_clock_output, .core_reset,
   .core_run, .pll_enable, .osc_enable, .low_power_mode);
`default_nettype wire
